// [src/zq_odt_pkg.sv]
// zq_odt_pkg: register map, field positions, reset values and timing
// constants for the termination and impedance-calibration controller.
// assumes one clock domain; the dram command clock is hclk.
package zq_odt_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_RTT = 8'h04;
   localparam logic [7:0] OFF_LAT = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0C;
   localparam logic [7:0] OFF_ERR = 8'h10;
   // control fields
   localparam int CTRL_BL_LO = 0;
   localparam int CTRL_PRE2 = 2;
   localparam int CTRL_CRC = 3;
   localparam int CTRL_DM = 4;
   localparam int CTRL_TDQS = 5;
   // termination value fields
   localparam int RTT_NOM_LO = 0;
   localparam int RTT_WR_LO = 4;
   localparam int RTT_PARK_LO = 8;
   // latency fields
   localparam int LAT_RL_LO = 0;
   localparam int LAT_WL_LO = 8;
   // status and error fields
   localparam int ST_BUSY = 0;
   localparam int ST_FIRST = 1;
   localparam int ST_TS_LO = 2;
   localparam int ST_BL8 = 5;
   localparam int ST_SR = 6;
   localparam int ST_CODE_LO = 8;
   localparam int ST_ODTRX = 16;
   localparam int ST_ZQI = 17;
   localparam int ERR_ACT = 0;
   localparam int ERR_CKE = 1;
   localparam int ERR_ODT = 2;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] RTT_RST = 32'h0000_0000;
   localparam logic [31:0] LAT_RST = 32'h0000_090F;
   localparam logic [7:0] CODE_RST = 8'h80;
   // burst and read-off timing terms, in command clocks
   localparam logic [5:0] X_1TCK = 6'h02;
   localparam logic [5:0] X_2TCK = 6'h03;
   localparam logic [5:0] Y_CRC = 6'h01;
   localparam logic [5:0] HALF_BL8 = 6'h04;
   localparam logic [5:0] HALF_BC4 = 6'h02;
   localparam logic [1:0] BL_FIX8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   // commands as decoded on the command pins
   typedef enum logic [2:0] {
      CMD_NOP = 3'b000, CMD_ZQCL = 3'b001, CMD_ZQCS = 3'b010,
      CMD_RD = 3'b011, CMD_WR = 3'b100, CMD_SRE = 3'b101,
      CMD_SRX = 3'b110, CMD_OTHER = 3'b111
   } cmd_t;
   typedef enum logic [2:0] {
      TS_HIZ = 3'b000, TS_PARK = 3'b001, TS_NOM = 3'b010,
      TS_WR = 3'b011, TS_RDOFF = 3'b100
   } term_state_t;
   typedef enum logic [1:0] {
      ZQ_IDLE = 2'b00, ZQ_CAL = 2'b01, ZQ_XFER = 2'b10
   } zq_state_t;
endpackage : zq_odt_pkg

// [src/term_sel_if.sv]
// term_sel_if: carries termination settings and windows to the selector
// and the resolved state back; both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface term_sel_if import zq_odt_pkg::*;;
   logic [2:0] nom;
   logic [1:0] wr;
   logic [2:0] park;
   logic odt_on;
   logic wr_win;
   logic rd_off;
   logic self_ref;
   term_state_t state;
   logic [2:0] code;
   modport ctl(output nom, wr, park, odt_on, wr_win, rd_off, self_ref,
      input state, code);
   modport sel(input nom, wr, park, odt_on, wr_win, rd_off, self_ref,
      output state, code);
endinterface : term_sel_if
`default_nettype wire

// [src/term_select.sv]
// term_select: resolves the termination source by fixed priority.
// assumes its inputs are already aligned to the cycle they apply to.
`timescale 1ns/1ps
`default_nettype none
module term_select import zq_odt_pkg::*; (
   term_sel_if.sel t
);
   // priority: self-refresh, read-off, write, nominal, park, hi-z
   always_comb begin
      t.state = TS_HIZ;
      t.code = 3'h0;
      if (t.self_ref) begin
         t.state = TS_HIZ;
      end else if (t.rd_off) begin
         t.state = TS_RDOFF;
      end else if (t.wr_win && t.wr != 2'h0) begin
         t.state = TS_WR;
         t.code = {1'b0, t.wr};
      end else if (t.odt_on && t.nom != 3'h0) begin
         t.state = TS_NOM;
         t.code = t.nom;
      end else if (t.park != 3'h0) begin
         t.state = TS_PARK;
         t.code = t.park;
      end
   end
endmodule : term_select
`default_nettype wire

// [src/dram_termination_zq_control.sv]
// dram_termination_zq_control: zq calibration sequencing and odt source
// selection for one dram die, with an ahb-lite register slave.
// assumes command pins, odt, cke and the analog engine code arrive
// asynchronously and are resampled here; hclk is the command clock.
`timescale 1ns/1ps
`default_nettype none
module dram_termination_zq_control import zq_odt_pkg::*; #(
   parameter int unsigned ZQINIT_NCK = 1024,
   parameter int unsigned ZQOPER_NCK = 512,
   parameter int unsigned ZQCS_NCK = 128
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_code,
   input wire logic burst_a12,
   input wire logic odt_pin,
   input wire logic cke_pin,
   input wire logic [7:0] engine_code,
   output logic [2:0] term_state,
   output logic [2:0] rtt_code,
   output logic dq_term_en,
   output logic tdqs_term_en,
   output logic odt_rx_en,
   output logic zq_current_en,
   output logic [7:0] io_code,
   output logic zq_busy
);
   localparam int PW = 15;
   // window lengths in command clocks, cast to the counter width
   localparam logic [15:0] ZQINIT_CNT = 16'(ZQINIT_NCK - 1);
   localparam logic [15:0] ZQOPER_CNT = 16'(ZQOPER_NCK - 1);
   localparam logic [15:0] ZQCS_CNT = 16'(ZQCS_NCK - 1);

   logic [PW-1:0] pin_s1_r, pin_s2_r;
   logic cv, a12, odt_s, cke_s, ap, dp_wr_r;
   cmd_t cmd;
   logic [7:0] eng_s, dp_addr_r;
   logic [31:0] ctrl_r, rtt_r, lat_r, stat, rd_val;
   logic [2:0] err_r, err_set, err_clr;
   zq_state_t zq_r;
   logic [15:0] zq_cnt_r;
   logic first_done_r, sr_r, bl8_r, odt_gated, odt_on, cur_bl8;
   logic [5:0] xv, yv, half, rl, wl, wl_lat, cur_len;
   // per window: 0 is read termination-off, 1 is write termination
   logic [5:0] win_dly_r [2];
   logic [5:0] win_len_r [2];
   logic [5:0] win_start [2];
   logic [1:0] win_hit;
   logic [63:0] odt_dly_r;

   term_sel_if tif();

   // two-flop resample of every asynchronous pin before use
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end else begin
         pin_s1_r <= {cmd_valid, cmd_code, burst_a12, odt_pin, cke_pin,
            engine_code};
         pin_s2_r <= pin_s1_r;
      end
   end
   assign cv = pin_s2_r[14];
   assign cmd = cmd_t'(pin_s2_r[13:11]);
   assign a12 = pin_s2_r[10];
   assign odt_s = pin_s2_r[9];
   assign cke_s = pin_s2_r[8];
   // the engine code is settled long before a transfer, so a wide
   // resample is safe here; it is only read at the transfer cycle
   assign eng_s = pin_s2_r[7:0];

   // ahb-lite address phase: only whole-word nonsequential or sequential transfers are taken
   assign ap = hsel && htrans[1] && hready && hsize == 3'b010;

   // latch the address phase for the write data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_r <= 1'b0;
         dp_addr_r <= 8'h00;
      end else begin
         dp_wr_r <= ap && hwrite;
         dp_addr_r <= haddr[7:0];
      end
   end

   // status view of the block's own state
   always_comb begin
      stat = 32'h0000_0000;
      stat[ST_BUSY] = zq_r != ZQ_IDLE;
      stat[ST_FIRST] = first_done_r;
      stat[ST_TS_LO +: 3] = term_state;
      stat[ST_BL8] = bl8_r;
      stat[ST_SR] = sr_r;
      stat[ST_CODE_LO +: 8] = io_code;
      stat[ST_ODTRX] = odt_rx_en;
      stat[ST_ZQI] = zq_current_en;
   end

   // read decode; unmapped offsets read as zero
   always_comb begin
      unique case (haddr[7:0])
         OFF_CTRL: rd_val = ctrl_r;
         OFF_RTT: rd_val = rtt_r;
         OFF_LAT: rd_val = lat_r;
         OFF_STAT: rd_val = stat;
         OFF_ERR: rd_val = {29'h0000_0000, err_r};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // zero-wait slave: read data is registered at the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hrdata <= (ap && !hwrite) ? rd_val : 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // mode-register shadows written in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= CTRL_RST;
         rtt_r <= RTT_RST;
         lat_r <= LAT_RST;
      end else if (dp_wr_r) begin
         if (dp_addr_r == OFF_CTRL) begin
            ctrl_r <= hwdata;
         end
         if (dp_addr_r == OFF_RTT) begin
            rtt_r <= hwdata;
         end
         if (dp_addr_r == OFF_LAT) begin
            lat_r <= hwdata;
         end
      end
   end

   // controller misbehaviour during calibration, kept sticky
   always_comb begin
      err_set = 3'h0;
      err_set[ERR_ACT] = zq_r == ZQ_CAL && cv;
      err_set[ERR_CKE] = zq_r == ZQ_CAL && !cke_s;
      err_set[ERR_ODT] = zq_r == ZQ_CAL && odt_s;
      err_clr = (dp_wr_r && dp_addr_r == OFF_ERR) ? hwdata[2:0] : 3'h0;
   end

   // write one to clear; a new event in the same cycle wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_r <= 3'h0;
      end else begin
         err_r <= (err_r & ~err_clr) | err_set;
      end
   end

   // calibration sequencer: window per command kind, then transfer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         zq_r <= ZQ_IDLE;
         zq_cnt_r <= 16'h0000;
         first_done_r <= 1'b0;
         zq_current_en <= 1'b0;
         io_code <= CODE_RST;
         zq_busy <= 1'b0;
      end else begin
         unique case (zq_r)
            ZQ_IDLE: begin
               // nothing starts on its own, not even after self-refresh
               if (cv && cmd == CMD_ZQCL && !sr_r) begin
                  zq_r <= ZQ_CAL;
                  zq_current_en <= 1'b1;
                  zq_busy <= 1'b1;
                  zq_cnt_r <= first_done_r ? ZQOPER_CNT : ZQINIT_CNT;
                  first_done_r <= 1'b1;
               end else if (cv && cmd == CMD_ZQCS && !sr_r) begin
                  zq_r <= ZQ_CAL;
                  zq_current_en <= 1'b1;
                  zq_busy <= 1'b1;
                  zq_cnt_r <= ZQCS_CNT;
               end
            end
            ZQ_CAL: begin
               // commands arriving here are ignored and flagged
               if (zq_cnt_r <= 16'h0001) begin
                  zq_r <= ZQ_XFER;
               end else begin
                  zq_cnt_r <= zq_cnt_r - 16'h0001;
               end
            end
            ZQ_XFER: begin
               // outside reset, io codes change only here, all bits at once
               io_code <= eng_s;
               zq_current_en <= 1'b0;
               zq_busy <= 1'b0;
               zq_r <= ZQ_IDLE;
            end
            default: begin
               zq_r <= ZQ_IDLE;
               zq_current_en <= 1'b0;
               zq_busy <= 1'b0;
            end
         endcase
      end
   end

   // self-refresh tracking from entry and exit commands
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sr_r <= 1'b0;
      end else if (cv && cmd == CMD_SRE) begin
         sr_r <= 1'b1;
      end else if (cv && cmd == CMD_SRX) begin
         sr_r <= 1'b0;
      end
   end

   // burst length of the current column command
   always_comb begin
      cur_bl8 = ctrl_r[CTRL_BL_LO +: 2] == BL_FIX8 ||
         (ctrl_r[CTRL_BL_LO +: 2] == BL_OTF && a12);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bl8_r <= 1'b0;
      end else if (cv && (cmd == CMD_RD || cmd == CMD_WR)) begin
         bl8_r <= cur_bl8;
      end
   end

   // latency terms from the mode shadows
   always_comb begin
      xv = ctrl_r[CTRL_PRE2] ? X_2TCK : X_1TCK;
      yv = ctrl_r[CTRL_CRC] ? Y_CRC : 6'h00;
      half = cur_bl8 ? HALF_BL8 : HALF_BC4;
      rl = lat_r[LAT_RL_LO +: 6];
      wl = lat_r[LAT_WL_LO +: 6];
      wl_lat = wl - xv;
      cur_len = half + xv + yv;
      win_start[0] = rl - xv;
      win_start[1] = wl_lat;
      win_hit = {cv && cmd == CMD_WR, cv && cmd == CMD_RD};
   end

   // read window starts RL-X, write window WL-X after its command;
   // a repeated command restarts the delay, the open length runs out
   for (genvar i = 0; i < 2; i++) begin : g_win
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            win_dly_r[i] <= 6'h00;
            win_len_r[i] <= 6'h00;
         end else if (win_hit[i]) begin
            if (win_start[i] <= 6'h01) begin
               win_len_r[i] <= cur_len;
               win_dly_r[i] <= 6'h00;
            end else begin
               win_dly_r[i] <= win_start[i] - 6'h01;
               win_len_r[i] <= (win_len_r[i] != 6'h00) ?
                  win_len_r[i] - 6'h01 : 6'h00;
            end
         end else if (win_dly_r[i] == 6'h01) begin
            win_dly_r[i] <= 6'h00;
            win_len_r[i] <= HALF_BL8 + xv + yv - (bl8_r ? 6'h00 : 6'h02);
         end else begin
            if (win_dly_r[i] != 6'h00) begin
               win_dly_r[i] <= win_dly_r[i] - 6'h01;
            end
            if (win_len_r[i] != 6'h00) begin
               win_len_r[i] <= win_len_r[i] - 6'h01;
            end
         end
      end
   end

   // odt pin gated off when nominal is disabled or in self-refresh
   assign odt_gated = odt_s && rtt_r[RTT_NOM_LO +: 3] != 3'h0 && !sr_r;

   // odt delay line so nominal follows the pin after WL-X clocks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         odt_dly_r <= 64'h0000_0000_0000_0000;
      end else begin
         odt_dly_r <= {odt_dly_r[62:0], odt_gated};
      end
   end
   assign odt_on = (wl_lat == 6'h00) ? odt_gated :
      odt_dly_r[wl_lat - 6'h01];

   // feed the selector
   assign tif.nom = rtt_r[RTT_NOM_LO +: 3];
   assign tif.wr = rtt_r[RTT_WR_LO +: 2];
   assign tif.park = rtt_r[RTT_PARK_LO +: 3];
   assign tif.odt_on = odt_on;
   assign tif.wr_win = win_len_r[1] != 6'h00;
   assign tif.rd_off = win_len_r[0] != 6'h00;
   assign tif.self_ref = sr_r;

   term_select u_sel (
      .t(tif.sel)
   );

   // registered termination outputs for the io ring
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         term_state <= TS_HIZ;
         rtt_code <= 3'h0;
         dq_term_en <= 1'b0;
         tdqs_term_en <= 1'b0;
         odt_rx_en <= 1'b0;
      end else begin
         term_state <= tif.state;
         rtt_code <= tif.code;
         // active only when some field selected a nonzero value
         dq_term_en <= tif.code != 3'h0;
         tdqs_term_en <= tif.code != 3'h0 && ctrl_r[CTRL_TDQS];
         // receiver powered down when nominal is disabled
         odt_rx_en <= rtt_r[RTT_NOM_LO +: 3] != 3'h0 && !sr_r;
      end
   end
endmodule : dram_termination_zq_control
`default_nettype wire

// [verif/dram_termination_zq_control_sva.sv]
// checker for the termination and calibration block, top ports only.
// assumes one clock, hclk, and the active low async reset hresetn.
`timescale 1ns/1ps
`default_nettype none
module dram_termination_zq_control_sva import zq_odt_pkg::*; #(
   parameter int unsigned ZQINIT_NCK = 1024
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [7:0] engine_code,
   input wire logic [2:0] term_state,
   input wire logic [2:0] rtt_code,
   input wire logic dq_term_en,
   input wire logic tdqs_term_en,
   input wire logic odt_rx_en,
   input wire logic zq_current_en,
   input wire logic [7:0] io_code,
   input wire logic zq_busy
);
   default clocking dc @(posedge hclk); endclocking
   default disable iff (!hresetn);
   int unsigned busy_cnt;
   // clocks spent busy; a stuck window shows up as an overlong count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= zq_busy ? busy_cnt + 1 : 0;
      end
   end
   property p_xfer;
      $fell(zq_busy) |-> io_code == $past(engine_code, 3);
   endproperty
   a_xfer: assert property (p_xfer) else $error("code not moved");
   property p_hold;
      $changed(io_code) |-> $fell(zq_busy);
   endproperty
   a_hold: assert property (p_hold) else $error("io code moved");
   property p_len;
      busy_cnt <= ZQINIT_NCK + 1;
   endproperty
   a_len: assert property (p_len) else $error("window too long");
   property p_cur;
      !zq_busy |-> !zq_current_en;
   endproperty
   a_cur: assert property (p_cur) else $error("current left on");
   property p_cal;
      zq_busy |-> term_state inside {TS_PARK, TS_HIZ};
   endproperty
   a_cal: assert property (p_cal) else $error("not parked");
   property p_en;
      dq_term_en == (rtt_code != 3'h0);
   endproperty
   a_en: assert property (p_en) else $error("enable vs code");
   property p_tdqs;
      tdqs_term_en |-> dq_term_en;
   endproperty
   a_tdqs: assert property (p_tdqs) else $error("tdqs alone");
   property p_hiz;
      term_state == TS_HIZ |-> rtt_code == 3'h0;
   endproperty
   a_hiz: assert property (p_hiz) else $error("hiz with code");
   property p_rdoff;
      term_state == TS_RDOFF |-> !dq_term_en && rtt_code == 3'h0;
   endproperty
   a_rdoff: assert property (p_rdoff) else $error("read on");
   property p_rx;
      !odt_rx_en |-> term_state != TS_NOM;
   endproperty
   a_rx: assert property (p_rx) else $error("nominal w/o rx");
endmodule : dram_termination_zq_control_sva
bind dram_termination_zq_control dram_termination_zq_control_sva #(
   .ZQINIT_NCK(ZQINIT_NCK)) chk (.hclk(hclk), .hresetn(hresetn),
   .engine_code(engine_code), .term_state(term_state),
   .rtt_code(rtt_code), .dq_term_en(dq_term_en),
   .tdqs_term_en(tdqs_term_en), .odt_rx_en(odt_rx_en),
   .zq_current_en(zq_current_en), .io_code(io_code), .zq_busy(zq_busy));
`default_nettype wire

// [verif/ddr_ctrl_model.sv]
// controller model driving the command, odt and cke pins of the block.
// assumes zq_busy from the block shows when calibration runs.
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_model import zq_odt_pkg::*; #(
   parameter int TRP_NCK = 3,
   parameter int XS_NCK = 4
) (
   input wire logic clk,
   input wire logic zq_busy,
   output logic cmd_valid,
   output logic [2:0] cmd_code,
   output logic burst_a12,
   output logic odt_pin,
   output logic cke_pin
);
   logic polite = 1'b1; // cleared only where a scenario wants misuse
   int idle = 0;
   // pins idle, cke registered high from the start
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 3'h0;
      burst_a12 = 1'b0;
      odt_pin = 1'b0;
      cke_pin = 1'b1;
   end
   // clocks since the last strobe; spaces commands by the precharge and exit times
   always @(posedge clk) idle <= cmd_valid ? 0 : idle + 1;
   // waits the gap, then if polite waits out busy, precharge and exit times; strobes one command
   task automatic issue(input cmd_t c, input logic a12, input int gap);
      repeat (gap) @(posedge clk);
      if (polite && c inside {CMD_ZQCL, CMD_ZQCS}) begin
         odt_pin <= 1'b0;
      end
      while (polite && (zq_busy || idle < TRP_NCK + XS_NCK)) begin
         @(posedge clk);
      end
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      burst_a12 <= a12;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_code <= ~c; // released pins never show the last command
      burst_a12 <= ~a12;
   endtask : issue
   task automatic set_odt(input logic v);
      @(posedge clk);
      odt_pin <= v;
   endtask : set_odt
   // misuse on request: cke low for one clock
   task automatic cke_drop;
      @(posedge clk);
      cke_pin <= 1'b0;
      @(posedge clk);
      cke_pin <= 1'b1;
   endtask : cke_drop
endmodule : ddr_ctrl_model
`default_nettype wire

// [verif/tb_dram_termination_zq_control.sv]
// testbench for the termination and calibration block.
// assumes the controller model on the pins and an ahb-lite master here.
`timescale 1ns/1ps
`default_nettype none
module tb_dram_termination_zq_control import zq_odt_pkg::*;;
   typedef struct {
      logic [11:0] rtt; logic [5:0] ctrl; logic odt; cmd_t cmd;
      logic a12; logic [2:0] st; logic [2:0] code; int len;
   } row_t;
   localparam int ZQI = 12;
   localparam int ZQO = 10;
   localparam int ZQS = 8;
   logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2, cmd_code, term_state, rtt_code;
   logic hreadyout, hresp, cmd_valid, burst_a12, odt_pin, cke_pin;
   logic dq_term_en, tdqs_term_en, odt_rx_en, zq_current_en, zq_busy;
   logic [7:0] engine_code = 8'h00, io_code;
   int failures = 0, tests_run = 0, n, d, lat, l1, l2, l3;
   row_t r;
   // steady selections first, then windows opened by writes and reads
   row_t rows[15] = '{
      '{12'h000, 6'h00, 1'b1, CMD_NOP, 1'b0, TS_HIZ, 3'h0, 0},
      '{12'h003, 6'h00, 1'b1, CMD_NOP, 1'b0, TS_NOM, 3'h3, 0},
      '{12'h003, 6'h00, 1'b0, CMD_NOP, 1'b0, TS_HIZ, 3'h0, 0},
      '{12'h503, 6'h00, 1'b0, CMD_NOP, 1'b0, TS_PARK, 3'h5, 0},
      '{12'h500, 6'h00, 1'b1, CMD_NOP, 1'b0, TS_PARK, 3'h5, 0},
      '{12'h523, 6'h20, 1'b1, CMD_NOP, 1'b0, TS_NOM, 3'h3, 0},
      '{12'h523, 6'h00, 1'b1, CMD_WR, 1'b0, TS_WR, 3'h2, 6},
      '{12'h523, 6'h00, 1'b0, CMD_WR, 1'b0, TS_WR, 3'h2, 6},
      '{12'h523, 6'h00, 1'b1, CMD_RD, 1'b0, TS_RDOFF, 3'h0, 6},
      '{12'h523, 6'h02, 1'b0, CMD_RD, 1'b0, TS_RDOFF, 3'h0, 4},
      '{12'h523, 6'h01, 1'b0, CMD_RD, 1'b1, TS_RDOFF, 3'h0, 6},
      '{12'h523, 6'h01, 1'b0, CMD_RD, 1'b0, TS_RDOFF, 3'h0, 4},
      '{12'h523, 6'h0c, 1'b0, CMD_RD, 1'b0, TS_RDOFF, 3'h0, 8},
      '{12'h523, 6'h0a, 1'b0, CMD_RD, 1'b0, TS_RDOFF, 3'h0, 5},
      '{12'h523, 6'h06, 1'b0, CMD_RD, 1'b0, TS_RDOFF, 3'h0, 5}};
   logic [7:0] ra[7] = '{OFF_CTRL, OFF_RTT, OFF_LAT, OFF_STAT, OFF_ERR,
      8'h20, OFF_ERR};
   logic [31:0] rv[7] = '{CTRL_RST, RTT_RST, LAT_RST, 32'h0000_8000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

   // 40 MHz command clock
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   dram_termination_zq_control #(.ZQINIT_NCK(ZQI), .ZQOPER_NCK(ZQO),
      .ZQCS_NCK(ZQS)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .burst_a12(burst_a12), .odt_pin(odt_pin),
      .cke_pin(cke_pin), .engine_code(engine_code),
      .term_state(term_state), .rtt_code(rtt_code),
      .dq_term_en(dq_term_en), .tdqs_term_en(tdqs_term_en),
      .odt_rx_en(odt_rx_en), .zq_current_en(zq_current_en),
      .io_code(io_code), .zq_busy(zq_busy));

   ddr_ctrl_model ctl (.clk(hclk), .zq_busy(zq_busy), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .burst_a12(burst_a12), .odt_pin(odt_pin),
      .cke_pin(cke_pin));

   task automatic report_and_stop;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one clock of any wait; a hang ends the run instead of the sim
   task automatic step(inout int k);
      @(posedge hclk);
      k++;
      if (k > 300) begin
         failures++;
         $display("[ERR] wait expected end seen none");
         report_and_stop();
      end
   endtask : step

   // counts clocks until busy or the termination state (un)matches v
   task automatic wt(input logic bsy, input logic [2:0] v, input logic eq,
      output int c);
      c = 0;
      while (((bsy ? {2'h0, zq_busy} : term_state) === v) !== eq) step(c);
   endtask : wt

   // single word transfer; each phase held until hready seen high
   task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] wd);
      int k;
      k = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= 32'(a);
      hwrite <= w;
      hsize <= 3'h2;
      do step(k); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do step(k); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb

   // one calibration: the new code must reach the io when busy ends
   task automatic zq(input cmd_t c, input logic [7:0] e, output int len);
      engine_code <= e;
      ctl.issue(c, 1'b0, 0);
      wt(1'b1, 3'h1, 1'b1, d);
      wt(1'b1, 3'h1, 1'b0, len);
      chk("io", 32'(io_code), 32'(e));
      chk("cur", 32'(zq_current_en), 32'h0000_0000);
   endtask : zq

   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      chk("io0", 32'(io_code), 32'(CODE_RST));
      ahb(1'b1, OFF_STAT, 32'hffff_ffff);
      ahb(1'b1, 8'h20, 32'hffff_ffff);
      foreach (ra[i]) begin
         ahb(1'b0, ra[i], 32'h0000_0000);
         chk("reg", rd, rv[i]);
      end
      // first long, later long and short calibrations
      zq(CMD_ZQCL, 8'h3c, l1);
      ahb(1'b0, OFF_STAT, 32'h0000_0000);
      chk("first", 32'(rd[ST_FIRST]), 32'h0000_0001);
      zq(CMD_ZQCL, 8'ha5, l2);
      zq(CMD_ZQCS, 8'h5a, l3);
      chk("init", l1 - l2, ZQI - ZQO);
      chk("short", l2 - l3, ZQO - ZQS);
      // misuse during a short window: a long command and cke low
      ctl.polite = 1'b0;
      engine_code <= 8'hc3;
      ctl.issue(CMD_ZQCS, 1'b0, 0);
      wt(1'b1, 3'h1, 1'b1, d);
      fork
         wt(1'b1, 3'h1, 1'b0, n);
         begin
            ctl.issue(CMD_ZQCL, 1'b0, 0);
            ctl.cke_drop();
         end
      join
      ctl.polite = 1'b1;
      chk("keep", n, l3);
      chk("io2", 32'(io_code), 32'h0000_00c3);
      ahb(1'b0, OFF_ERR, 32'h0000_0000);
      chk("err", rd & 32'h0000_0003, 32'h0000_0003);
      ahb(1'b1, OFF_ERR, 32'h0000_0007);
      ahb(1'b0, OFF_ERR, 32'h0000_0000);
      chk("errclr", rd, 32'h0000_0000);
      // selection table, then read and write windows
      foreach (rows[i]) begin
         r = rows[i];
         ahb(1'b1, OFF_RTT, 32'(r.rtt));
         ahb(1'b1, OFF_CTRL, 32'(r.ctrl));
         ctl.set_odt(r.odt);
         repeat (16) @(posedge hclk);
         if (r.cmd == CMD_NOP) begin
            chk("state", 32'(term_state), 32'(r.st));
            chk("code", 32'(rtt_code), 32'(r.code));
            chk("rx", 32'(odt_rx_en), 32'(r.rtt[2:0] != 0));
            chk("tdqs", 32'(tdqs_term_en),
               32'(r.code != 0 && r.ctrl[5]));
         end else begin
            ctl.issue(r.cmd, r.a12, 0);
            wt(1'b0, r.st, 1'b1, d);
            chk("wcode", 32'(rtt_code), 32'(r.code));
            wt(1'b0, r.st, 1'b0, n);
            chk("len", n, r.len);
            // RL or WL less X, plus two resample clocks and one to see it
            lat = (r.cmd == CMD_RD ? 15 : 9) - (r.ctrl[2] ? 3 : 2) + 3;
            chk("delay", d, lat);
            ahb(1'b0, OFF_STAT, 32'h0000_0000);
            chk("bl8", 32'(rd[ST_BL8]), 32'(r.ctrl[1:0] == 2'h0 ||
               (r.ctrl[1:0] == 2'h1 && r.a12)));
         end
      end
      // self-refresh: hi-z, odt and calibration ignored until exit
      ctl.set_odt(1'b1);
      ctl.issue(CMD_SRE, 1'b0, 0);
      repeat (16) @(posedge hclk);
      chk("srst", 32'(term_state), 32'(TS_HIZ));
      chk("srrx", 32'(odt_rx_en), 32'h0000_0000);
      ahb(1'b0, OFF_STAT, 32'h0000_0000);
      chk("sr", 32'(rd[ST_SR]), 32'h0000_0001);
      ctl.polite = 1'b0;
      ctl.issue(CMD_ZQCS, 1'b0, 0);
      ctl.polite = 1'b1;
      ctl.set_odt(1'b0);
      ctl.issue(CMD_SRX, 1'b0, 0);
      repeat (16) @(posedge hclk);
      chk("nocal", 32'(zq_busy), 32'h0000_0000);
      chk("io3", 32'(io_code), 32'h0000_00c3);
      chk("park", 32'(term_state), 32'(TS_PARK));
      zq(CMD_ZQCS, 8'h96, n);
      chk("srlen", n, ZQS);
      // second reset in mid-run
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      chk("rio", 32'(io_code), 32'(CODE_RST));
      hresetn <= 1'b1;
      ahb(1'b0, OFF_STAT, 32'h0000_0000);
      chk("rst", rd, 32'h0000_8000);
      report_and_stop();
   end
endmodule : tb_dram_termination_zq_control
`default_nettype wire
